// [src/wake_frame_detect_regs.vh]
// register offsets, field positions, reset values and timing counts
`ifndef WAKE_FRAME_DETECT_REGS_VH
`define WAKE_FRAME_DETECT_REGS_VH

// register byte offsets on the apb bus
`define WFD_CTRL_ADDR      12'h000
`define WFD_STATUS_ADDR    12'h004
`define WFD_MASK_ADDR      12'h008
`define WFD_STATION_LO     12'h00c
`define WFD_STATION_HI     12'h010
`define WFD_PASS_LO        12'h014
`define WFD_PASS_HI        12'h018
`define WFD_PULSE_ADDR     12'h01c
`define WFD_PAT_LEN_ADDR   12'h020
`define WFD_PAT_BASE       12'h100
`define WFD_PAT_MASK_BASE  12'h200

// control register fields
`define WFD_CTRL_SIG_EN    0
`define WFD_CTRL_PASS_EN   1
`define WFD_CTRL_PAT_EN    2
`define WFD_CTRL_BCAST_EN  3
`define WFD_CTRL_UCAST_EN  4
`define WFD_CTRL_LEVEL     5
`define WFD_CTRL_GPIO_LSB  6
`define WFD_CTRL_WIDTH     8
`define WFD_CTRL_RESET     8'h00

// status and mask fields
`define WFD_ST_SIG         0
`define WFD_ST_PASS        1
`define WFD_ST_PAT         2
`define WFD_ST_CRC_BAD     3
`define WFD_ST_WIDTH       4

// signature layout
`define WFD_SYNC_BYTES     6
`define WFD_ADDR_COPIES    16
`define WFD_PAT_BYTES      64
`define WFD_GPIO_COUNT     4

// default pulse width in system clocks
`define WFD_PULSE_RESET    8'h04

`endif

// [src/wake_crc32.v]
// crc-32 checker over received bytes, reflected ethernet polynomial
`timescale 1ns/1ps
module wake_crc32 (
  // clock and reset
  input  wire        SYS_CLK,
  input  wire        RST,
  // byte stream
  input  wire        clear,
  input  wire        byte_valid,
  input  wire [7:0]  byte_data,
  // result
  output wire        crc_good
);
  reg  [31:0] crc;        // running remainder
  reg  [31:0] next_crc;   // remainder after this byte
  integer     i;

  // bitwise update, lsb first as on the wire
  always @* begin
    next_crc = crc;
    for (i = 0; i < 8; i = i + 1) begin
      if (next_crc[0] ^ byte_data[i])
        next_crc = (next_crc >> 1) ^ 32'hedb88320;
      else
        next_crc = next_crc >> 1;
    end
  end

  // preset at frame start, folds in each byte
  always @(posedge SYS_CLK) begin
    if (RST || clear)
      crc <= 32'hffffffff;
    else if (byte_valid)
      crc <= next_crc;
  end

  // residue after a good fcs has been folded in
  assign crc_good = (crc == 32'hdebb20e3);
endmodule

// [src/wake_event_out.v]
// wake notification shaper: pulse or level on a selected gpio
`timescale 1ns/1ps
module wake_event_out (
  // clock and reset
  input  wire       SYS_CLK,
  input  wire       RST,
  // control
  input  wire       fire,
  input  wire       level_mode,
  input  wire       level_clear,
  input  wire [1:0] gpio_sel,
  input  wire [7:0] pulse_len,
  // gpio pins
  output reg  [3:0] gpio
);
  reg       active;  // event currently shown
  reg [7:0] count;   // pulse cycles left

  // level holds until cleared; pulse counts down (set wins over clear)
  always @(posedge SYS_CLK) begin
    if (RST) begin
      active <= 1'b0;
      count  <= 8'h00;
    end else if (fire) begin
      active <= 1'b1;
      count  <= (pulse_len == 8'h00) ? 8'h01 : pulse_len;
    end else if (level_mode) begin
      if (level_clear)
        active <= 1'b0;
    end else if (count > 8'h01) begin
      count <= count - 8'h01;
    end else begin
      active <= 1'b0;
      count  <= 8'h00;
    end
  end

  // drive only the chosen pin, registered
  always @(posedge SYS_CLK) begin
    if (RST)
      gpio <= 4'h0;
    else
      gpio <= active ? (4'h1 << gpio_sel) : 4'h0;
  end
endmodule

// [src/wake_frame_detector.v]
// wake frame detector: signature, password and pattern match with apb regs
`timescale 1ns/1ps
`include "wake_frame_detect_regs.vh"

// Contract
// [RULE_01] notify by status, gpio or interrupt
// [RULE_02] detect signature, password, custom pattern
// [RULE_03] wake event as pulse or level
// [RULE_04] detection independent of line speed
// [RULE_05] bad crc suppresses wake interrupt
// [RULE_06] password must follow signature when enabled
// [RULE_07] one 64-byte configurable pattern wakes
// [RULE_08] broadcast and unicast enables independent
// [RULE_09] six 0xff bytes start signature
// [RULE_10] sixteen station address copies then password
// [RULE_11] scan only own or broadcast destination
// [RULE_12] signature compared on whole bytes
// [RULE_13] status sticky; partial match dropped at frame end
module wake_frame_detector (
  // clock and reset
  input  wire        SYS_CLK,
  input  wire        RST,
  // receive byte stream from the pcs
  input  wire        RX_FRAME,
  input  wire        RX_VALID,
  input  wire [7:0]  RX_DATA,
  // apb slave
  input  wire        PSEL,
  input  wire        PENABLE,
  input  wire        PWRITE,
  input  wire [11:0] PADDR,
  input  wire [31:0] PWDATA,
  output reg  [31:0] PRDATA,
  output wire        PREADY,
  output wire        PSLVERR,
  // notification
  output wire        IRQ,
  output wire [3:0]  GPIO_WAKE
);
  // pin synchronisers: two flops before any logic
  reg        frame_s1;
  reg        frame_s2;
  reg        valid_s1;
  reg        valid_s2;
  reg [7:0]  data_s1;
  reg [7:0]  data_s2;
  reg        frame_d;   // previous synced frame level

  // configuration registers
  reg [`WFD_CTRL_WIDTH-1:0] ctrl;
  reg [`WFD_ST_WIDTH-1:0]   status;
  reg [`WFD_ST_WIDTH-1:0]   mask;
  reg [47:0] station;      // own station address, byte 0 first on wire
  reg [47:0] password;     // password bytes
  reg [7:0]  pulse_len;    // gpio pulse width
  reg [6:0]  pat_len;      // pattern length in bytes, 1..64
  reg [7:0]  pattern [0:`WFD_PAT_BYTES-1];
  reg [`WFD_PAT_BYTES-1:0] pat_care; // per byte compare enable

  // frame parsing state
  reg [10:0] pos;          // byte index in frame
  reg        addr_ok;      // destination accepted so far
  reg        is_bcast;     // destination all ones so far
  reg        is_ucast;     // destination equals station so far
  reg [2:0]  sync_run;     // count of consecutive 0xff
  reg [6:0]  sig_cnt;      // address bytes matched
  reg [2:0]  pass_cnt;     // password bytes matched
  reg        sig_found;    // signature seen in this frame
  reg        pass_found;   // signature plus password seen
  reg        pat_ok;       // pattern still matching
  reg [2:0]  state;
  reg [2:0]  next_state;

  // scan states
  localparam ST_HUNT = 3'd0;  // looking for sync run
  localparam ST_ADDR = 3'd1;  // matching address copies
  localparam ST_PASS = 3'd2;  // matching password
  localparam ST_DONE = 3'd3;  // signature complete

  wire       byte_en;    // one synced byte this cycle
  wire       frame_end;  // falling edge of frame
  wire       frame_beg;  // rising edge of frame
  wire       crc_good;
  wire [7:0] sta_byte;   // expected station byte
  wire [7:0] pwd_byte;   // expected password byte
  wire       pass_need;
  wire       wr;
  wire       rd;
  wire [3:0] set_ev;     // status events this cycle
  wire       fire;

  // synchronise all receive pins to the system clock
  always @(posedge SYS_CLK) begin
    if (RST) begin
      frame_s1 <= 1'b0;
      frame_s2 <= 1'b0;
      valid_s1 <= 1'b0;
      valid_s2 <= 1'b0;
      data_s1  <= 8'h00;
      data_s2  <= 8'h00;
      frame_d  <= 1'b0;
    end else begin
      frame_s1 <= RX_FRAME;
      frame_s2 <= frame_s1;
      valid_s1 <= RX_VALID;
      valid_s2 <= valid_s1;
      data_s1  <= RX_DATA;
      data_s2  <= data_s1;
      frame_d  <= frame_s2;
    end
  end

  // byte stream is speed agnostic: any rate of valid strobes works
  assign byte_en   = valid_s2 && frame_s2;                       // RULE_04
  assign frame_end = frame_d && !frame_s2;
  assign frame_beg = frame_s2 && !frame_d;

  // expected address byte cycles through the six station bytes
  assign sta_byte = station[8*((sig_cnt % 7'd6) + 7'd0) +: 8];  // RULE_10
  assign pwd_byte = password[8*pass_cnt +: 8];
  assign pass_need = ctrl[`WFD_CTRL_PASS_EN];

  // crc over the whole frame including fcs
  wake_crc32 u_crc (
    .SYS_CLK    (SYS_CLK),
    .RST        (RST),
    .clear      (frame_beg),
    .byte_valid (byte_en),
    .byte_data  (data_s2),
    .crc_good   (crc_good)
  );

  // signature scanner next state, whole bytes only
  always @* begin
    next_state = state;
    case (state)
      ST_HUNT: begin
        if (byte_en && sync_run == 3'd5 && data_s2 == 8'hff)  // RULE_09
          next_state = ST_ADDR;
      end
      ST_ADDR: begin
        if (byte_en) begin
          if (data_s2 != sta_byte)                          // RULE_12
            next_state = ST_HUNT;
          else if (sig_cnt == 7'd95)
            next_state = pass_need ? ST_PASS : ST_DONE;      // RULE_06
        end
      end
      ST_PASS: begin
        if (byte_en) begin
          if (data_s2 != pwd_byte)
            next_state = ST_HUNT;
          else if (pass_cnt == 3'd5)
            next_state = ST_DONE;
        end
      end
      ST_DONE: next_state = ST_DONE;
      default: next_state = ST_HUNT;
    endcase
  end

  // per-frame tracking; everything partial dies at frame end
  always @(posedge SYS_CLK) begin
    if (RST || frame_beg || frame_end) begin                 // RULE_13
      state      <= ST_HUNT;
      pos        <= 11'd0;
      addr_ok    <= 1'b1;
      is_bcast   <= 1'b1;
      is_ucast   <= 1'b1;
      sync_run   <= 3'd0;
      sig_cnt    <= 7'd0;
      pass_cnt   <= 3'd0;
      sig_found  <= 1'b0;
      pass_found <= 1'b0;
      pat_ok     <= 1'b1;
    end else if (byte_en) begin
      state <= next_state;
      if (pos != 11'h7ff)
        pos <= pos + 11'd1;
      // destination filter over the first six bytes
      if (pos < 11'd6) begin                                 // RULE_11
        if (data_s2 != 8'hff)
          is_bcast <= 1'b0;
        if (data_s2 != station[8*pos[2:0] +: 8])
          is_ucast <= 1'b0;
      end
      // sync run counter saturates at six
      if (data_s2 == 8'hff)
        sync_run <= (sync_run == 3'd6) ? 3'd6 : sync_run + 3'd1;
      else
        sync_run <= 3'd0;
      // address copy counter
      if (state == ST_ADDR && next_state == ST_ADDR)
        sig_cnt <= sig_cnt + 7'd1;
      else
        sig_cnt <= 7'd0;
      if (state == ST_PASS && next_state == ST_PASS)
        pass_cnt <= pass_cnt + 3'd1;
      else
        pass_cnt <= 3'd0;
      // record a complete signature
      if (next_state == ST_DONE && state != ST_DONE) begin
        sig_found  <= 1'b1;
        pass_found <= pass_need;
      end
      // a 0xff tail inside the address run may restart a sync
      if (state == ST_ADDR && next_state == ST_HUNT &&
          data_s2 == 8'hff)
        sync_run <= 3'd1;
      // custom pattern over the first pat_len bytes
      if (pos < {4'h0, pat_len} && pos < 11'd64 &&
          pat_care[pos[5:0]] &&
          data_s2 != pattern[pos[5:0]])                      // RULE_07
        pat_ok <= 1'b0;
    end
  end

  // addressed test combines independent broadcast and unicast enables
  wire dest_hit = (is_bcast && ctrl[`WFD_CTRL_BCAST_EN]) ||
                  (is_ucast && !is_bcast &&
                   ctrl[`WFD_CTRL_UCAST_EN]);                // RULE_08
  wire pat_done = pos >= {4'h0, pat_len};

  // wake events are judged at frame end, only with a good crc; the bad-crc flag needs a bad one
  wire good_end = frame_end && dest_hit && crc_good;         // RULE_05
  assign set_ev[`WFD_ST_SIG]  = good_end && sig_found &&
                                ctrl[`WFD_CTRL_SIG_EN] && !pass_need;
  assign set_ev[`WFD_ST_PASS] = good_end && pass_found &&
                                ctrl[`WFD_CTRL_SIG_EN];      // RULE_06
  assign set_ev[`WFD_ST_PAT]  = good_end && pat_ok && pat_done &&
                                ctrl[`WFD_CTRL_PAT_EN];      // RULE_02
  assign set_ev[`WFD_ST_CRC_BAD] = frame_end && dest_hit && !crc_good &&
                                   (sig_found || (pat_ok && pat_done));
  assign fire = |set_ev[2:0];

  // apb: zero wait states, writes take effect on the access edge
  assign PREADY  = 1'b1;
  assign PSLVERR = 1'b0;
  assign wr = PSEL && PENABLE && PWRITE;
  assign rd = PSEL && !PWRITE;

  // configuration writes
  always @(posedge SYS_CLK) begin
    if (RST) begin
      ctrl      <= `WFD_CTRL_RESET;
      mask      <= {`WFD_ST_WIDTH{1'b0}};
      station   <= 48'h0;
      password  <= 48'h0;
      pulse_len <= `WFD_PULSE_RESET;
      pat_len   <= 7'd64;
      pat_care  <= {`WFD_PAT_BYTES{1'b0}};
    end else if (wr) begin
      case (PADDR)
        `WFD_CTRL_ADDR:   ctrl          <= PWDATA[7:0];
        `WFD_MASK_ADDR:   mask          <= PWDATA[3:0];
        `WFD_STATION_LO:  station[31:0] <= PWDATA;
        `WFD_STATION_HI:  station[47:32] <= PWDATA[15:0];
        `WFD_PASS_LO:     password[31:0] <= PWDATA;
        `WFD_PASS_HI:     password[47:32] <= PWDATA[15:0];
        `WFD_PULSE_ADDR:  pulse_len     <= PWDATA[7:0];
        `WFD_PAT_LEN_ADDR: begin
          // length clipped to the 64 byte store
          if (PWDATA[6:0] == 7'd0 || PWDATA[6:0] > 7'd64)
            pat_len <= 7'd64;
          else
            pat_len <= PWDATA[6:0];
        end
        default: begin
          if (PADDR[11:8] == 4'h2)
            pat_care[PADDR[7:2]] <= PWDATA[0];
        end
      endcase
    end
  end

  // pattern byte store, one per word
  genvar g;
  generate
    for (g = 0; g < `WFD_PAT_BYTES; g = g + 1) begin : pat_store
      always @(posedge SYS_CLK) begin
        if (RST)
          pattern[g] <= 8'h00;
        else if (wr && PADDR == (`WFD_PAT_BASE + 4*g))
          pattern[g] <= PWDATA[7:0];
      end
    end
  endgenerate

  // sticky status: hardware set wins over write-one-to-clear
  always @(posedge SYS_CLK) begin
    if (RST)
      status <= {`WFD_ST_WIDTH{1'b0}};
    else
      status <= (status & ~((wr && PADDR == `WFD_STATUS_ADDR) ?
                            PWDATA[3:0] : 4'h0)) | set_ev;   // RULE_13
  end

  // level interrupt from unmasked sticky bits
  assign IRQ = |(status & mask);                             // RULE_01

  // read mux, registered in setup so it is ready in access
  always @(posedge SYS_CLK) begin
    if (RST)
      PRDATA <= 32'h0;
    else if (rd && !PENABLE) begin
      case (PADDR)
        `WFD_CTRL_ADDR:    PRDATA <= {24'h0, ctrl};
        `WFD_STATUS_ADDR:  PRDATA <= {28'h0, status};
        `WFD_MASK_ADDR:    PRDATA <= {28'h0, mask};
        `WFD_STATION_LO:   PRDATA <= station[31:0];
        `WFD_STATION_HI:   PRDATA <= {16'h0, station[47:32]};
        `WFD_PASS_LO:      PRDATA <= password[31:0];
        `WFD_PASS_HI:      PRDATA <= {16'h0, password[47:32]};
        `WFD_PULSE_ADDR:   PRDATA <= {24'h0, pulse_len};
        `WFD_PAT_LEN_ADDR: PRDATA <= {25'h0, pat_len};
        default: begin
          if (PADDR[11:8] == 4'h1)
            PRDATA <= {24'h0, pattern[PADDR[7:2]]};
          else if (PADDR[11:8] == 4'h2)
            PRDATA <= {31'h0, pat_care[PADDR[7:2]]};
          else
            PRDATA <= 32'h0; // unmapped reads as zero
        end
      endcase
    end
  end

  // gpio wake event, pulse or level chosen by software
  wake_event_out u_evt (
    .SYS_CLK     (SYS_CLK),
    .RST         (RST),
    .fire        (fire),                                     // RULE_03
    .level_mode  (ctrl[`WFD_CTRL_LEVEL]),
    .level_clear (wr && PADDR == `WFD_STATUS_ADDR),
    .gpio_sel    (ctrl[`WFD_CTRL_GPIO_LSB +: 2]),
    .pulse_len   (pulse_len),
    .gpio        (GPIO_WAKE)
  );
endmodule

// [verification/wake_frame_detector_properties.sv]
// port checker for the wake frame detector, bound to the design top
`timescale 1ns/1ps
`include "wake_frame_detect_regs.vh"
module wake_frame_detector_properties (
  // clock and reset
  input wire        SYS_CLK,
  input wire        RST,
  // receive stream
  input wire        RX_FRAME,
  // apb
  input wire        PSEL,
  input wire        PENABLE,
  input wire        PWRITE,
  input wire [11:0] PADDR,
  input wire [31:0] PWDATA,
  input wire [31:0] PRDATA,
  input wire        PREADY,
  // notification
  input wire        IRQ,
  input wire [3:0]  GPIO_WAKE
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  reg  [7:0] since_end;                       // cycles since frame end
  wire       wr_access = PSEL && PENABLE && PWRITE; // write lands here
  // saturating count; set to idle on reset so no wake looks pending
  always @(posedge SYS_CLK) begin
    if (RST)
      since_end <= 8'hff;
    else if (RX_FRAME)
      since_end <= 8'h00;
    else if (since_end != 8'hff)
      since_end <= since_end + 8'h01;
  end
  // full status clear while no frame result can be pending
  sequence s_clear_all;
    PSEL && !PENABLE && PWRITE && PADDR == `WFD_STATUS_ADDR &&
      PWDATA[3:0] == 4'hf && since_end > 8'h20 ##1 wr_access;
  endsequence
  a_irq_clear_all: assert property (s_clear_all |=> !IRQ)
    else $error("irq stays after full status clear");
  a_irq_sticky: assert property (IRQ && !wr_access |=> IRQ)
    else $error("irq dropped without a write");
  a_irq_after_frame: assert property ($rose(IRQ) && !$past(wr_access)
    |-> since_end >= 8'h01 && since_end <= 8'h0c)
    else $error("irq rose away from a frame end");
  a_gpio_after_frame: assert property ($rose(|GPIO_WAKE)
    |-> since_end >= 8'h02 && since_end <= 8'h0d)
    else $error("gpio rose away from a frame end");
  a_gpio_one_pin: assert property ($onehot0(GPIO_WAKE))
    else $error("more than one wake pin driven");
  a_read_data_holds: assert property (!$past(RST)
    && !$past(PSEL && !PENABLE && !PWRITE) |-> $stable(PRDATA))
    else $error("read data moved without a read");
  a_irq_reset_low: assert property ($past(RST) |-> !IRQ && PRDATA == 0)
    else $error("irq or read data set after reset");
  a_gpio_reset_low: assert property ($past(RST) |-> GPIO_WAKE == 4'h0)
    else $error("gpio set after reset");
  a_ready_always: assert property (PREADY)
    else $error("status bus stalled");
endmodule
bind wake_frame_detector wake_frame_detector_properties chk (
  .SYS_CLK(SYS_CLK), .RST(RST), .RX_FRAME(RX_FRAME), .PSEL(PSEL),
  .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .IRQ(IRQ), .GPIO_WAKE(GPIO_WAKE));

// [verification/wake_rx_source.sv]
// receive byte source standing in for the line side
`timescale 1ns/1ps
module wake_rx_source (
  // clock
  input  wire        SYS_CLK,
  // receive stream
  output logic       RX_FRAME,
  output logic       RX_VALID,
  output logic [7:0] RX_DATA
);
  logic [7:0] frame_q [$]; // bytes of the next frame, fcs included
  logic       busy;        // a frame is on the stream
  initial begin
    RX_FRAME = 1'b0;
    RX_VALID = 1'b0;
    RX_DATA  = 8'h00;
    busy     = 1'b0;
  end
  // idle data keeps toggling so a stale byte can never look valid
  always @(posedge SYS_CLK) begin
    if (!busy)
      RX_DATA <= ~RX_DATA;
  end
  // send the queue; gap idle cycles after each byte sets the line rate
  task automatic send(input int gap);
    busy = 1'b1;
    @(posedge SYS_CLK);
    RX_FRAME <= 1'b1;
    while (frame_q.size() > 0) begin
      @(posedge SYS_CLK);
      RX_VALID <= 1'b1;
      RX_DATA  <= frame_q.pop_front();
      repeat (gap) begin
        @(posedge SYS_CLK);
        RX_VALID <= 1'b0;
        RX_DATA  <= ~RX_DATA;
      end
    end
    @(posedge SYS_CLK);
    RX_FRAME <= 1'b0;
    busy = 1'b0;
  endtask
endmodule

// [verification/wake_frame_detector_tb_top.sv]
// self-checking bench for the wake frame detector
`timescale 1ns/1ps
`include "wake_frame_detect_regs.vh"
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("Error at %0t: got %h expected %h", $time, g, e); end end
module wake_frame_detector_tb_top;
  localparam logic [47:0] STATION = 48'he5d4c3b2a102; // own address
  logic        SYS_CLK = 1'b0;
  logic        RST     = 1'b1;
  logic        PSEL    = 1'b0;
  logic        PENABLE = 1'b0;
  logic        PWRITE  = 1'b0;
  logic [11:0] PADDR   = 12'h000;
  logic [31:0] PWDATA  = 32'h0;
  wire         RX_FRAME, RX_VALID, PREADY, PSLVERR, IRQ;
  wire  [7:0]  RX_DATA;
  wire  [31:0] PRDATA;
  wire  [3:0]  GPIO_WAKE;
  logic [31:0] rd;           // last word read
  logic [3:0]  seen;         // wake pins seen after the frame
  int          fails = 0;
  int          num_checks = 0;
  wake_frame_detector uut (.SYS_CLK(SYS_CLK), .RST(RST),
    .RX_FRAME(RX_FRAME), .RX_VALID(RX_VALID), .RX_DATA(RX_DATA),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
    .PSLVERR(PSLVERR), .IRQ(IRQ), .GPIO_WAKE(GPIO_WAKE));
  wake_rx_source rx (.SYS_CLK(SYS_CLK), .RX_FRAME(RX_FRAME),
    .RX_VALID(RX_VALID), .RX_DATA(RX_DATA));
  // 20 MHz system clock
  always #25 SYS_CLK = ~SYS_CLK;
  // one apb transfer; the request stands until pready is seen
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL   <= 1'b1;
    PWRITE <= w;
    PADDR  <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    rd = PRDATA;
    PSEL    <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // append n copies of a byte, or a 48-bit value first byte first
  task automatic put(input logic [7:0] b, input int n);
    repeat (n) rx.frame_q.push_back(b);
  endtask
  task automatic put48(input logic [47:0] v);
    for (int i = 0; i < 6; i++) put(v[8*i +: 8], 1);
  endtask
  // build, send and watch one frame; bad spoils the fcs
  task automatic frame(input logic [47:0] dst, input logic [47:0] pw,
                       input logic bad, input int gap);
    logic [31:0] c;
    put48(dst);
    put48(48'h0a0b0c0d0e0f);
    put(8'h45, 5); // filler ahead of the signature
    put(8'hff, 6);
    repeat (16) put48(STATION);
    put48(pw);
    c = 32'hffffffff;
    for (int i = 0; i < rx.frame_q.size(); i++) begin
      c = c ^ {24'h0, rx.frame_q[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 32'hedb88320 : c >> 1;
    end
    c = ~c ^ {31'h0, bad};
    for (int i = 0; i < 4; i++) put(c[8*i +: 8], 1);
    rx.send(gap);
    seen = 4'h0;
    repeat (8) begin
      @(posedge SYS_CLK);
      seen = seen | GPIO_WAKE;
    end
    apb(1'b0, `WFD_STATUS_ADDR, 32'h0);
  endtask
  // clear all status bits
  task automatic clr;
    apb(1'b1, `WFD_STATUS_ADDR, 32'hf);
    @(posedge SYS_CLK);
  endtask
  task automatic t_reset;
    apb(1'b0, `WFD_CTRL_ADDR, 32'h0);
    `CHK(rd[7:0], `WFD_CTRL_RESET)
    apb(1'b0, `WFD_PULSE_ADDR, 32'h0);
    `CHK(rd[7:0], `WFD_PULSE_RESET)
    apb(1'b0, 12'h0fc, 32'h0);
    `CHK(rd, 32'h0)
    `CHK(PSLVERR, 1'b0)
  endtask
  // signature at a given byte spacing, pulse on pin 1, sticky status
  task automatic t_sig(input int gap);
    apb(1'b1, `WFD_CTRL_ADDR, 32'h51);
    frame(STATION, 48'h0, 1'b0, gap);
    `CHK(rd[3:0], 4'h1)
    `CHK(seen, 4'h2)
    repeat (20) @(posedge SYS_CLK);
    `CHK(IRQ, 1'b1)
    clr();
    `CHK(IRQ, 1'b0)
  endtask
  // spoilt fcs: masked bad-frame flag only, no wake
  task automatic t_crc;
    frame(STATION, 48'h0, 1'b1, 1);
    `CHK(rd[3:0], 4'h8)
    `CHK({IRQ, seen}, 5'h00)
    clr();
  endtask
  // password must follow the copies
  task automatic t_pass;
    apb(1'b1, `WFD_CTRL_ADDR, 32'h53);
    apb(1'b1, `WFD_PASS_LO, 32'h2d2c2b2a);
    apb(1'b1, `WFD_PASS_HI, 32'h00002f2e);
    frame(STATION, 48'h2f2e2d2c2b2a, 1'b0, 1);
    `CHK(rd[1], 1'b1)
    clr();
    frame(STATION, 48'h2f2e2d2c2b2b, 1'b0, 1);
    `CHK(rd[1], 1'b0)
    clr();
  endtask
  // broadcast and unicast enables against destination kinds
  task automatic t_addr;
    logic [7:0]  c [4] = '{8'h09, 8'h11, 8'h11, 8'h09};
    logic [47:0] d [4] = '{48'hffffffffffff, 48'hffffffffffff,
                           48'h0000a1b2c3d4, STATION};
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `WFD_CTRL_ADDR, {24'h0, c[i]});
      frame(d[i], 48'h0, 1'b0, 1);
      `CHK(rd[3:0], (i == 0) ? 4'h1 : 4'h0)
      clr();
    end
  endtask
  // pattern over bytes 0..7 and the last byte 63
  task automatic t_pat;
    logic [7:0] p [8] = '{8'h02, 8'ha1, 8'hb2, 8'hc3, 8'hd4, 8'he5,
                          8'h0f, 8'h0e};
    apb(1'b1, `WFD_CTRL_ADDR, 32'h14);
    for (int i = 0; i < 8; i++) begin
      apb(1'b1, `WFD_PAT_BASE + 12'(4*i), {24'h0, p[i]});
      apb(1'b1, `WFD_PAT_MASK_BASE + 12'(4*i), 32'h1);
    end
    apb(1'b1, `WFD_PAT_MASK_BASE + 12'(4*63), 32'h1);
    apb(1'b1, `WFD_PAT_BASE + 12'(4*63), 32'hd4);
    frame(STATION, 48'h0, 1'b0, 1);
    `CHK(rd[3:0], 4'h4)
    clr();
    apb(1'b1, `WFD_PAT_BASE + 12'(4*63), 32'h2b);
    frame(STATION, 48'h0, 1'b0, 1);
    `CHK(rd[3:0], 4'h0)
  endtask
  // level on pin 2 stands until a status write
  task automatic t_level;
    apb(1'b1, `WFD_CTRL_ADDR, 32'hb1);
    frame(STATION, 48'h0, 1'b0, 1);
    repeat (30) @(posedge SYS_CLK);
    `CHK(GPIO_WAKE, 4'h4)
    clr();
    @(posedge SYS_CLK);
    `CHK(GPIO_WAKE, 4'h0)
  endtask
  // reset in mid-run empties status
  task automatic t_midreset;
    frame(STATION, 48'h0, 1'b0, 1);
    RST <= 1'b1;
    repeat (3) @(posedge SYS_CLK);
    RST <= 1'b0;
    apb(1'b0, `WFD_STATUS_ADDR, 32'h0);
    `CHK({IRQ, rd[3:0]}, 5'h00)
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // main sequence
  initial begin
    repeat (12) @(posedge SYS_CLK);
    RST <= 1'b0;
    t_reset();
    apb(1'b1, `WFD_STATION_LO, STATION[31:0]);
    apb(1'b1, `WFD_STATION_HI, {16'h0, STATION[47:32]});
    apb(1'b1, `WFD_MASK_ADDR, 32'h7);
    t_sig(1);
    t_sig(7);
    t_crc();
    t_pass();
    t_addr();
    t_pat();
    t_level();
    t_midreset();
    print_verdict();
  end
  // watchdog well beyond the expected run
  initial begin
    repeat (40000) @(posedge SYS_CLK);
    fails++;
    print_verdict();
  end
endmodule
